// [aomd_ctrl_unit.sv]
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// control unit reading one ratiometric output level
module aomd_ctrl_unit (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [11:0] out_code,
	output logic      [11:0] seen_code,
	output logic             err_band
);
	// band edges at 4 and 96 percent of full scale
	localparam logic [11:0] LOW_EDGE  = 12'h0a4;
	localparam logic [11:0] HIGH_EDGE = 12'hf5c;

	// only the level is visible here, so an error is any code outside the band edges
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			seen_code <= 12'h000;
			err_band  <= 1'b1;
		end else begin
			seen_code <= out_code;
			err_band  <= (out_code < LOW_EDGE) ||
				(out_code > HIGH_EDGE);
		end
	end
endmodule

`default_nettype wire

// [aomd_pkg.sv]
package aomd_pkg;
	// nvm word map, one 22-bit codeword per 16-bit value
	localparam logic [3:0] AOMD_NW   = 4'ha;
	localparam logic [3:0] AOMD_ZERO = 4'h0;
	localparam logic [3:0] AOMD_MAXA = 4'h1;
	localparam logic [3:0] AOMD_SWA  = 4'h2;
	localparam logic [3:0] AOMD_UPC  = 4'h3;
	localparam logic [3:0] AOMD_LOC  = 4'h4;
	localparam logic [3:0] AOMD_CFG  = 4'h5;
	localparam logic [3:0] AOMD_OFS  = 4'h6;
	localparam logic [3:0] AOMD_ID0  = 4'h7;
	localparam logic [3:0] AOMD_ID1  = 4'h8;
	localparam logic [3:0] AOMD_CRCW = 4'h9;
	// configuration word bits
	localparam int AOMD_FALL  = 0;
	localparam int AOMD_MLEN  = 1;
	localparam int AOMD_DHIGH = 2;
	localparam int AOMD_LOCK  = 3;
	// channel-local register groups, bus_addr[7] picks the channel
	localparam int         AOMD_CH_BIT  = 7;
	localparam logic [2:0] AOMD_G_WORD  = 3'h0;
	localparam logic [2:0] AOMD_G_RAW   = 3'h1;
	localparam logic [6:0] AOMD_R_STAT  = 7'h20;
	localparam logic [6:0] AOMD_R_ANGLE = 7'h21;
	localparam logic [6:0] AOMD_R_DAC   = 7'h22;
	// output codes and arithmetic constants
	localparam logic [11:0] AOMD_DIAG_LOW  = 12'h020;
	localparam logic [11:0] AOMD_DIAG_HIGH = 12'hfe0;
	localparam logic [7:0]  AOMD_CRC_POLY  = 8'h07;
	localparam logic [7:0]  AOMD_CRC_INIT  = 8'hff;
	localparam logic [3:0]  AOMD_ITERS     = 4'he;
	localparam logic [3:0]  AOMD_DIVS      = 4'hc;
	localparam logic [15:0] AOMD_HALF      = 16'h8000;
	localparam logic signed [17:0] AOMD_ML_MIN = 18'sh00200;
	localparam logic [15:0] AOMD_ATAN [0:13] = '{16'h2000, 16'h12e4,
		16'h09fb, 16'h0511, 16'h028b, 16'h0146, 16'h00a3, 16'h0051,
		16'h0029, 16'h0014, 16'h000a, 16'h0005, 16'h0003, 16'h0001};
	localparam logic [15:0] AOMD_DEF [0:8] = '{16'h0000, 16'h8000,
		16'hc000, 16'h0e66, 16'h019a, 16'h0000, 16'h0000, 16'h0000,
		16'h0000};

	typedef enum logic [2:0] {
		AOMD_INIT, AOMD_IDLE, AOMD_OFFS, AOMD_CORD, AOMD_ADJ, AOMD_DIV
	} aomd_state_type;

	function automatic logic [21:0] aomd_encode(input logic [15:0] d);
		logic [21:0] c;
		logic [4:0]  s;
		int          k;
		c = '0;
		s = '0;
		k = 0;
		for (int p = 1; p < 22; p++) begin
			if ((p & (p - 1)) != 0) begin
				c[p] = d[k];
				k++;
			end
		end
		for (int p = 1; p < 22; p++) begin
			if (c[p])
				s = s ^ 5'(p);
		end
		for (int j = 0; j < 5; j++)
			c[1 << j] = s[j];
		c[0] = ^c[21:1];
		return c;
	endfunction

	// returns {double, single, data}
	function automatic logic [17:0] aomd_decode(input logic [21:0] cw);
		logic [21:0] c;
		logic [15:0] d;
		logic [4:0]  s;
		logic        par;
		logic        dbl;
		int          k;
		c = cw;
		d = '0;
		s = '0;
		k = 0;
		for (int p = 1; p < 22; p++) begin
			if (c[p])
				s = s ^ 5'(p);
		end
		par = ^c;
		dbl = (s != 5'h00) && (!par || s > 5'h15);
		if (par && s != 5'h00 && s < 5'h16)
			c[s] = ~c[s];
		for (int p = 1; p < 22; p++) begin
			if ((p & (p - 1)) != 0) begin
				d[k] = c[p];
				k++;
			end
		end
		return {dbl, par && !dbl, d};
	endfunction

	function automatic logic [7:0] aomd_crc(input logic [7:0] cin,
		input logic [15:0] d);
		logic [7:0] c;
		logic       fb;
		c = cin;
		for (int b = 15; b >= 0; b--) begin
			fb = c[7] ^ d[b];
			c = {c[6:0], 1'b0};
			if (fb)
				c = c ^ AOMD_CRC_POLY;
		end
		return c;
	endfunction
endpackage

// [aomd_top.sv]
// Operation
// - each 16-bit word is stored as a 22-bit protected codeword
// - single flipped bit is corrected silently, no diagnostic raised
// - two bad bits in one word force diagnostic mode
// - after reset a CRC over memory verifies the programmed data
// - once the lock bit is set no memory write is accepted
// - angle maps linearly to output, rising or falling slope
// - rising, above max but below switch angle gives upper clamp
// - rising, above switch angle up to full turn gives lower clamp
// - falling slope swaps the upper and lower clamp levels
// - valid codes stay within clamps, error codes below 4 or above 96%
// - output repeats every 360 degrees of field angle
// - angle is taken relative to a programmable zero angle
// - magnet loss raises diagnostic only when its enable is set
// - each channel picks a low or high diagnostic level
// - sequencer runs offset cancel, rotation angle, then adjustment
// - two user-writable 16-bit identification words per channel
// - two channel instances, independent apart from the shared undervoltage pin and program port
// - memory access only through the one shared program port, bus_addr[7] picks the channel
// - during initialization copy memory and hold low diagnostic level
// - undervoltage sets a status flag and forces diagnostic mode
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// one channel: memory, sequencer, mapping, diagnostics
module aomd_channel (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        sample_valid,
	input  wire logic [11:0] sample_x,
	input  wire logic [11:0] sample_y,
	input  wire logic        uv_pin,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	input  wire logic [6:0]  bus_addr,
	input  wire logic [21:0] bus_wdata,
	output logic      [11:0] dac,
	output logic             diag,
	output logic      [31:0] rd_value
);
	typedef struct packed {
		aomd_pkg::aomd_state_type st;
		logic [3:0]        idx;
		logic [7:0]        crc;
		logic [8:0][15:0]  sh;
		logic              done;
		logic              crc_fail;
		logic              dbl;
		logic              corr;
		logic              uv;
		logic              uv_s1;
		logic              uv_s2;
		logic              ml;
		logic              diag;
		logic signed [17:0] x;
		logic signed [17:0] y;
		logic [15:0]       z;
		logic [15:0]       rel;
		logic [3:0]        it;
		logic [27:0]       rem;
		logic [27:0]       d;
		logic [11:0]       q;
		logic [11:0]       val;
		logic [11:0]       dac;
	} aomd_ch_type;

	aomd_ch_type        r;
	aomd_ch_type        n;
	logic [21:0]        nvm [0:15];
	logic               nvm_we;
	logic [3:0]         nvm_wa;
	logic [21:0]        nvm_wd;
	logic [3:0]         rd_idx;
	logic [17:0]        dec;
	logic               lock;
	logic               fall;
	logic               word_ok;
	logic               diag_c;
	logic [15:0]        rel_c;
	logic [15:0]        maxa;
	logic [15:0]        swa;
	logic [11:0]        up;
	logic [11:0]        lo;
	logic [11:0]        span;
	logic signed [17:0] xs;
	logic signed [17:0] ys;

	// ============================================================
	// nvm array: survives resetn, loads a factory image at power-up
	// faults are injected through raw codeword writes
	initial begin
		logic [7:0] c;
		c = aomd_pkg::AOMD_CRC_INIT;
		for (int i = 0; i < 16; i++)
			nvm[i] = '0;
		for (int i = 0; i < 9; i++) begin
			nvm[i] = aomd_pkg::aomd_encode(aomd_pkg::AOMD_DEF[i]);
			c = aomd_pkg::aomd_crc(c, aomd_pkg::AOMD_DEF[i]);
		end
		nvm[aomd_pkg::AOMD_CRCW] = aomd_pkg::aomd_encode({8'h00, c});
	end

	// plain always: the power-up image above also writes this array
	always @(posedge clk) begin
		if (nvm_we)
			nvm[nvm_wa] <= nvm_wd;
	end

	// ============================================================
	// decode and configuration views
	assign rd_idx  = (r.st == aomd_pkg::AOMD_INIT) ? r.idx : bus_addr[3:0];
	assign dec     = aomd_pkg::aomd_decode(nvm[rd_idx]);
	assign lock    = r.sh[aomd_pkg::AOMD_CFG][aomd_pkg::AOMD_LOCK];
	assign fall    = r.sh[aomd_pkg::AOMD_CFG][aomd_pkg::AOMD_FALL];
	assign maxa    = r.sh[aomd_pkg::AOMD_MAXA];
	assign swa     = r.sh[aomd_pkg::AOMD_SWA];
	assign up      = r.sh[aomd_pkg::AOMD_UPC][11:0];
	assign lo      = r.sh[aomd_pkg::AOMD_LOC][11:0];
	assign span    = up - lo;
	assign word_ok = bus_addr[3:0] < aomd_pkg::AOMD_NW;
	// the 16-bit angle wraps at a full turn of the field
	assign rel_c   = r.z - r.sh[aomd_pkg::AOMD_ZERO];
	assign xs = r.x - 18'(signed'(r.sh[aomd_pkg::AOMD_OFS][15:8]));
	assign ys = r.y - 18'(signed'(r.sh[aomd_pkg::AOMD_OFS][7:0]));

	assign diag_c = !r.done || r.crc_fail || r.dbl || r.uv_s2 ||
		(r.ml && r.sh[aomd_pkg::AOMD_CFG][aomd_pkg::AOMD_MLEN]);

	always_comb begin
		n        = r;
		nvm_we   = 1'b0;
		nvm_wa   = bus_addr[3:0];
		nvm_wd   = aomd_pkg::aomd_encode(bus_wdata[15:0]);
		rd_value = '0;
		n.uv_s1  = uv_pin;
		n.uv_s2  = r.uv_s1;
		if (r.uv_s2)
			n.uv = 1'b1;

		// program port writes, blocked for good once locked
		if (bus_wr && r.done && !lock && word_ok) begin
			if (bus_addr[6:4] == aomd_pkg::AOMD_G_WORD) begin
				nvm_we = 1'b1;
				// id words are plain storage
				if (bus_addr[3:0] != aomd_pkg::AOMD_CRCW)
					n.sh[bus_addr[3:0]] = bus_wdata[15:0];
			end else if (bus_addr[6:4] == aomd_pkg::AOMD_G_RAW) begin
				nvm_we = 1'b1;
				nvm_wd = bus_wdata;
			end
		end

		if (bus_rd) begin
			if (bus_addr[6:4] == aomd_pkg::AOMD_G_WORD && word_ok &&
				r.done) begin
				rd_value = {16'h0000, dec[15:0]};
				if (dec[17])
					n.dbl = 1'b1;
				if (dec[16])
					n.corr = 1'b1;
			end else if (bus_addr[6:4] == aomd_pkg::AOMD_G_RAW && word_ok) begin
				rd_value = {10'h000, nvm[bus_addr[3:0]]};
			end else if (bus_addr == aomd_pkg::AOMD_R_STAT) begin
				rd_value = {24'h000000, lock, r.diag, r.ml, r.uv, r.corr,
					r.dbl, r.crc_fail, r.done};
			end else if (bus_addr == aomd_pkg::AOMD_R_ANGLE) begin
				rd_value = {16'h0000, r.rel};
			end else if (bus_addr == aomd_pkg::AOMD_R_DAC) begin
				rd_value = {20'h00000, r.dac};
			end
		end

		// ============================================================
		// sequencer
		case (r.st)
			aomd_pkg::AOMD_INIT: begin
				// copy into shadows while checking the crc
				n.idx = r.idx + 4'h1;
				if (dec[17])
					n.dbl = 1'b1;
				if (dec[16])
					n.corr = 1'b1;
				if (r.idx != aomd_pkg::AOMD_CRCW) begin
					n.sh[r.idx] = dec[15:0];
					n.crc = aomd_pkg::aomd_crc(r.crc, dec[15:0]);
				end else begin
					if (dec[7:0] != r.crc)
						n.crc_fail = 1'b1;
					n.done = 1'b1;
					n.st = aomd_pkg::AOMD_IDLE;
				end
			end
			aomd_pkg::AOMD_IDLE: begin
				// samples offered while busy are dropped, not queued
				if (sample_valid) begin
					n.x  = 18'(signed'(sample_x));
					n.y  = 18'(signed'(sample_y));
					n.st = aomd_pkg::AOMD_OFFS;
				end
			end
			aomd_pkg::AOMD_OFFS: begin
				// offset cancel, then fold into the right half plane
				n.it = 4'h0;
				n.st = aomd_pkg::AOMD_CORD;
				if (xs < 0) begin
					n.x = -xs;
					n.y = -ys;
					n.z = aomd_pkg::AOMD_HALF;
				end else begin
					n.x = xs;
					n.y = ys;
					n.z = 16'h0000;
				end
			end
			aomd_pkg::AOMD_CORD: begin
				// vectoring rotation drives y to zero
				n.it = r.it + 4'h1;
				if (r.y >= 0) begin
					n.x = r.x + (r.y >>> r.it);
					n.y = r.y - (r.x >>> r.it);
					n.z = r.z + aomd_pkg::AOMD_ATAN[r.it];
				end else begin
					n.x = r.x - (r.y >>> r.it);
					n.y = r.y + (r.x >>> r.it);
					n.z = r.z - aomd_pkg::AOMD_ATAN[r.it];
				end
				if (r.it == aomd_pkg::AOMD_ITERS - 4'h1)
					n.st = aomd_pkg::AOMD_ADJ;
			end
			aomd_pkg::AOMD_ADJ: begin
				// zero angle and range adjustment
				n.rel = rel_c;
				n.ml  = r.x < aomd_pkg::AOMD_ML_MIN;
				n.st  = aomd_pkg::AOMD_IDLE;
				if (rel_c <= maxa && maxa != 16'h0000) begin
					n.rem = 28'(rel_c) * 28'(span);
					n.d   = {1'b0, maxa, 11'h000};
					n.q   = 12'h000;
					n.it  = 4'h0;
					n.st  = aomd_pkg::AOMD_DIV;
				end else if (rel_c <= maxa) begin
					n.val = fall ? up : lo;
				end else if (rel_c < swa) begin
					n.val = fall ? lo : up;
				end else begin
					n.val = fall ? up : lo;
				end
			end
			aomd_pkg::AOMD_DIV: begin
				// rel*span/max, one quotient bit per cycle
				n.it = r.it + 4'h1;
				n.d  = r.d >> 1;
				if (r.rem >= r.d) begin
					n.rem = r.rem - r.d;
					n.q   = {r.q[10:0], 1'b1};
				end else begin
					n.q = {r.q[10:0], 1'b0};
				end
				if (r.it == aomd_pkg::AOMD_DIVS - 4'h1) begin
					n.val = fall ? up - n.q : lo + n.q;
					n.st  = aomd_pkg::AOMD_IDLE;
				end
			end
			default: n.st = aomd_pkg::AOMD_INIT;
		endcase

		// diagnostic level wins over the mapped code
		n.diag = diag_c;
		if (!r.done)
			n.dac = aomd_pkg::AOMD_DIAG_LOW;
		else if (diag_c)
			n.dac = r.sh[aomd_pkg::AOMD_CFG][aomd_pkg::AOMD_DHIGH] ?
				aomd_pkg::AOMD_DIAG_HIGH : aomd_pkg::AOMD_DIAG_LOW;
		else
			n.dac = r.val;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			r       <= '0;
			r.st    <= aomd_pkg::AOMD_INIT;
			r.crc   <= aomd_pkg::AOMD_CRC_INIT;
			r.diag  <= 1'b1;
			r.dac   <= aomd_pkg::AOMD_DIAG_LOW;
			// no sample yet: keep the low diagnostic code, not zero
			r.val   <= aomd_pkg::AOMD_DIAG_LOW;
		end else begin
			r <= n;
		end
	end

	assign dac  = r.dac;
	assign diag = r.diag;

	// ============================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_init_low;
		!r.done |=> (r.dac == aomd_pkg::AOMD_DIAG_LOW);
	endproperty
	a_init_low: assert property (p_init_low)
		else $error("output not at low diagnostic level during init");

	property p_dbl_diag;
		(r.st == aomd_pkg::AOMD_INIT && dec[17]) |=> r.dbl ##1 r.diag;
	endproperty
	a_dbl_diag: assert property (p_dbl_diag)
		else $error("double bit error did not force diagnostic mode");

	property p_single_ok;
		(r.st == aomd_pkg::AOMD_INIT && dec[16] && !r.dbl)
			|=> (r.corr && !r.dbl);
	endproperty
	a_single_ok: assert property (p_single_ok)
		else $error("single bit error raised a diagnostic");

	property p_lock;
		lock |-> !nvm_we;
	endproperty
	a_lock: assert property (p_lock)
		else $error("memory written while locked");

	property p_crc_hold;
		r.crc_fail |=> (r.crc_fail && r.diag);
	endproperty
	a_crc_hold: assert property (p_crc_hold)
		else $error("crc failure did not hold diagnostic mode");

	property p_clamp_up;
		(r.st == aomd_pkg::AOMD_ADJ && !fall && rel_c > maxa && rel_c < swa)
			|=> (r.val == $past(up));
	endproperty
	a_clamp_up: assert property (p_clamp_up)
		else $error("upper clamp not applied");

	property p_clamp_lo;
		(r.st == aomd_pkg::AOMD_ADJ && !fall && rel_c > maxa && rel_c >= swa)
			|=> (r.val == $past(lo));
	endproperty
	a_clamp_lo: assert property (p_clamp_lo)
		else $error("lower clamp not applied above switch angle");

	property p_fall_swap;
		(r.st == aomd_pkg::AOMD_ADJ && fall && rel_c > maxa && rel_c < swa)
			|=> (r.val == $past(lo));
	endproperty
	a_fall_swap: assert property (p_fall_swap)
		else $error("falling slope did not swap clamps");

	property p_in_range;
		(r.st == aomd_pkg::AOMD_DIV &&
			r.it == aomd_pkg::AOMD_DIVS - 4'h1 && up >= lo)
			|=> (r.val >= $past(lo) && r.val <= $past(up));
	endproperty
	a_in_range: assert property (p_in_range)
		else $error("linear code outside clamp levels");

	property p_diag_high;
		(r.done && diag_c &&
			r.sh[aomd_pkg::AOMD_CFG][aomd_pkg::AOMD_DHIGH])
			|=> (r.dac == aomd_pkg::AOMD_DIAG_HIGH);
	endproperty
	a_diag_high: assert property (p_diag_high)
		else $error("high diagnostic level not driven");

	property p_ml_off;
		(r.done && !r.crc_fail && !r.dbl && !r.uv_s2 &&
			!r.sh[aomd_pkg::AOMD_CFG][aomd_pkg::AOMD_MLEN]) |=> !r.diag;
	endproperty
	a_ml_off: assert property (p_ml_off)
		else $error("diagnostic raised with magnet loss disabled");

	property p_uv;
		r.uv_s2 |=> (r.uv && r.diag);
	endproperty
	a_uv: assert property (p_uv)
		else $error("undervoltage not flagged");

	property p_seq;
		(r.st == aomd_pkg::AOMD_IDLE && sample_valid)
			|-> ##[17:29] (r.st == aomd_pkg::AOMD_IDLE);
	endproperty
	a_seq: assert property (p_seq)
		else $error("sample processing did not finish in time");

	c_crc_fail: cover property (!r.crc_fail ##1 r.crc_fail);
	c_corr: cover property (r.done && r.corr && !r.dbl);
	c_clamp: cover property (r.st == aomd_pkg::AOMD_ADJ && !fall &&
		rel_c > maxa && rel_c >= swa);
	c_div: cover property (r.st == aomd_pkg::AOMD_DIV ##1
		r.st == aomd_pkg::AOMD_IDLE);
endmodule

// ============================================================
// two independent channels behind one program port
module aomd_top (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [7:0]  bus_addr,
	input  wire logic [31:0] bus_wdata,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	output logic      [31:0] bus_rdata,
	input  wire logic        undervolt_pin,
	input  wire logic        ch1_sample_valid,
	input  wire logic [11:0] ch1_sample_x,
	input  wire logic [11:0] ch1_sample_y,
	input  wire logic        ch2_sample_valid,
	input  wire logic [11:0] ch2_sample_x,
	input  wire logic [11:0] ch2_sample_y,
	output logic      [11:0] first_output_program_pin_dac,
	output logic             first_output_program_pin_diag,
	output logic      [11:0] second_output_program_pin_dac,
	output logic             second_output_program_pin_diag
);
	typedef struct packed {
		logic [31:0] rdata;
	} aomd_top_type;

	aomd_top_type r;
	aomd_top_type n;
	logic         sel2;
	logic [31:0]  v1;
	logic [31:0]  v2;

	assign sel2 = bus_addr[aomd_pkg::AOMD_CH_BIT];

	// each channel sees only its own half of the map
	aomd_channel u_ch1 (
		.clk          (clk),
		.resetn       (resetn),
		.sample_valid (ch1_sample_valid),
		.sample_x     (ch1_sample_x),
		.sample_y     (ch1_sample_y),
		.uv_pin       (undervolt_pin),
		.bus_wr       (bus_wr && !sel2),
		.bus_rd       (bus_rd && !sel2),
		.bus_addr     (bus_addr[6:0]),
		.bus_wdata    (bus_wdata[21:0]),
		.dac          (first_output_program_pin_dac),
		.diag         (first_output_program_pin_diag),
		.rd_value     (v1)
	);

	aomd_channel u_ch2 (
		.clk          (clk),
		.resetn       (resetn),
		.sample_valid (ch2_sample_valid),
		.sample_x     (ch2_sample_x),
		.sample_y     (ch2_sample_y),
		.uv_pin       (undervolt_pin),
		.bus_wr       (bus_wr && sel2),
		.bus_rd       (bus_rd && sel2),
		.bus_addr     (bus_addr[6:0]),
		.bus_wdata    (bus_wdata[21:0]),
		.dac          (second_output_program_pin_dac),
		.diag         (second_output_program_pin_diag),
		.rd_value     (v2)
	);

	always_comb begin
		n = r;
		n.rdata = bus_rd ? (sel2 ? v2 : v1) : 32'h00000000;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			r <= '0;
		else
			r <= n;
	end

	assign bus_rdata = r.rdata;
endmodule

`default_nettype wire

// [aomd_top_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// bench for both channels, bus tasks plus sample stimulus
module aomd_top_tb_top;
	localparam int LO = 32'h19a;
	localparam int UP = 32'he66;
	localparam logic [11:0] VX [0:3] = '{12'h5a8, 12'h000, 12'ha58, 12'h5a8};
	localparam logic [11:0] VY [0:3] = '{12'h5a8, 12'h7ff, 12'ha58, 12'ha58};
	localparam int          RL [0:3] = '{32'h2000, 32'h4000, 32'ha000, 32'he000};

	logic        clk;
	logic        resetn;
	logic [7:0]  bus_addr;
	logic [31:0] bus_wdata;
	logic        bus_wr;
	logic        bus_rd;
	logic [31:0] bus_rdata;
	logic        undervolt_pin;
	logic        sv;
	logic [11:0] sx;
	logic [11:0] sy;
	logic [11:0] dac1;
	logic [11:0] dac2;
	logic        diag1;
	logic        diag2;
	logic [11:0] seen1;
	logic [11:0] seen2;
	logic        err1;
	logic        err2;
	logic [31:0] v;
	logic [11:0] e;
	int          n_mismatch;
	int          cmp_count;

	aomd_top dut (.clk(clk), .resetn(resetn), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata(bus_rdata), .undervolt_pin(undervolt_pin),
		.ch1_sample_valid(sv), .ch1_sample_x(sx), .ch1_sample_y(sy),
		.ch2_sample_valid(sv), .ch2_sample_x(sx), .ch2_sample_y(sy),
		.first_output_program_pin_dac(dac1),
		.first_output_program_pin_diag(diag1),
		.second_output_program_pin_dac(dac2),
		.second_output_program_pin_diag(diag2));
	aomd_ctrl_unit cu1 (.clk(clk), .resetn(resetn), .out_code(dac1),
		.seen_code(seen1), .err_band(err1));
	aomd_ctrl_unit cu2 (.clk(clk), .resetn(resetn), .out_code(dac2),
		.seen_code(seen2), .err_band(err2));

	always #20 clk = ~clk;

	// ============================================================
	// shared tasks
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp, input int tol);
		int d;
		cmp_count++;
		d = int'(seen) - int'(exp);
		if ((^seen === 1'bx) || d > tol || d < -tol) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus_addr  <= a;
		bus_wdata <= d;
		bus_wr    <= 1'b1;
		@(posedge clk);
		bus_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		bus_addr <= a;
		bus_rd   <= 1'b1;
		@(posedge clk);
		bus_rd   <= 1'b0;
		#1;
		v = bus_rdata;
	endtask

	task automatic rc(input string nm, input logic [7:0] a,
		input logic [31:0] m, input logic [31:0] x, input int tol);
		rd(a);
		chk(nm, v & m, x, tol);
	endtask

	// result lands 30 cycles after the take edge, so 34 leaves margin
	task automatic smp(input logic [11:0] x, input logic [11:0] y);
		@(posedge clk);
		sx <= x;
		sy <= y;
		sv <= 1'b1;
		@(posedge clk);
		sv <= 1'b0;
		repeat (34) @(posedge clk);
		#1;
	endtask

	task automatic rst;
		@(posedge clk);
		resetn <= 1'b0;
		repeat (8) @(posedge clk);
		chk("dac_rst", 32'(dac1), 32'h020, 0);
		chk("diag_rst", 32'(diag1), 32'h1, 0);
		resetn <= 1'b1;
		repeat (5) @(posedge clk);
		#1;
		chk("dac_init", 32'(dac1), 32'h020, 0);
		repeat (9) @(posedge clk);
	endtask

	function automatic logic [11:0] lin(input int r, input logic fall);
		int s;
		s = (r * (UP - LO)) / 32768;
		return fall ? 12'(UP - s) : 12'(LO + s);
	endfunction

	task automatic fin(input string nm);
		$display("test %s done", nm);
	endtask

	task automatic test_done;
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ============================================================
	// watchdog, the sequence needs about 640 cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		test_done();
	end

	// ============================================================
	// main sequence
	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		bus_addr = 8'h00;
		bus_wdata = 32'h0;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		undervolt_pin = 1'b0;
		sv = 1'b0;
		sx = 12'h000;
		sy = 12'h000;
		n_mismatch = 0;
		cmp_count = 0;
		rst();
		rc("stat", 8'h20, 32'h03, 32'h01, 0);
		for (int i = 0; i < 5; i++)
			rc("word", 8'(i), 32'hffff, 32'(aomd_pkg::AOMD_DEF[i]), 0);
		rc("raw1", 8'h11, 32'h3fffff, 32'h210012, 0);
		fin("init");
		for (int f = 0; f < 2; f++) begin
			wr(8'h05, 32'(f));
			for (int i = 0; i < 4; i++) begin
				smp(VX[i], VY[i]);
				e = (i < 2) ? lin(RL[i], f[0]) :
					(((i == 2) ^ f[0]) ? 12'(UP) : 12'(LO));
				chk("map", 32'(seen1), 32'(e), 3);
				chk("band", 32'(err1), 32'h0, 0);
			end
		end
		fin("mapping");
		wr(8'h05, 32'h0);
		wr(8'h00, 32'h2000);
		smp(VX[1], VY[1]);
		chk("zero", 32'(seen1), 32'(lin(32'h2000, 1'b0)), 3);
		rc("angle", 8'h21, 32'hffff, 32'h2000, 32'h20);
		wr(8'h00, 32'h0);
		fin("zero");
		smp(12'h000, 12'h000);
		chk("ml_off", 32'(diag1), 32'h0, 0);
		wr(8'h05, 32'h2);
		smp(12'h000, 12'h000);
		chk("ml_on", 32'(diag1), 32'h1, 0);
		chk("ml_low", 32'(seen1), 32'h020, 0);
		wr(8'h05, 32'h6);
		smp(12'h000, 12'h000);
		chk("ml_high", 32'(seen1), 32'hfe0, 0);
		chk("band_hi", 32'(err1), 32'h1, 0);
		rc("dac_reg", 8'h22, 32'hfff, 32'hfe0, 0);
		wr(8'h05, 32'h0);
		smp(VX[1], VY[1]);
		chk("ml_gone", 32'(diag1), 32'h0, 0);
		fin("magnet");
		wr(8'h97, 32'h8);
		rc("corr_v", 8'h87, 32'hffff, 32'h0, 0);
		rc("corr_s", 8'ha0, 32'h0c, 32'h08, 0);
		chk("corr_d", 32'(diag2), 32'h0, 0);
		wr(8'h97, 32'h18);
		rd(8'h87);
		rc("dbl_s", 8'ha0, 32'h04, 32'h04, 0);
		chk("dbl_d", 32'(diag2), 32'h1, 0);
		chk("indep", 32'(diag1), 32'h0, 0);
		smp(VX[1], VY[1]);
		chk("dbl_out", 32'(seen2), 32'h020, 0);
		chk("ch1_out", 32'(seen1), 32'(lin(RL[1], 1'b0)), 3);
		chk("band2", 32'(err2), 32'h1, 0);
		// single flip in ch2 word 6, seen by the next copy after reset
		wr(8'h96, 32'h8);
		fin("ecc");
		wr(8'h07, 32'hbeef);
		wr(8'h08, 32'h1234);
		rc("id0", 8'h07, 32'hffff, 32'hbeef, 0);
		rc("id1", 8'h08, 32'hffff, 32'h1234, 0);
		fin("ident");
		@(posedge clk);
		undervolt_pin <= 1'b1;
		repeat (6) @(posedge clk);
		#1;
		chk("uv_d", 32'(diag1), 32'h1, 0);
		rc("uv_s", 8'h20, 32'h10, 32'h10, 0);
		@(posedge clk);
		undervolt_pin <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
		chk("uv_off", 32'(diag1), 32'h0, 0);
		fin("undervolt");
		wr(8'h05, 32'h8);
		wr(8'h03, 32'h0f00);
		rc("lock_w", 8'h03, 32'hffff, 32'(UP), 0);
		rc("lock_s", 8'h20, 32'h80, 32'h80, 0);
		fin("lock");
		// cfg and id words changed without a new crc word
		rst();
		rc("crc_s", 8'h20, 32'h03, 32'h03, 0);
		chk("crc_d", 32'(diag1), 32'h1, 0);
		chk("crc_o", 32'(seen1), 32'h020, 0);
		rc("ecc_init", 8'ha0, 32'h0c, 32'h0c, 0);
		wr(8'h03, 32'h0f00);
		rc("lock_p", 8'h03, 32'hffff, 32'(UP), 0);
		fin("crc");
		test_done();
	end
endmodule

`default_nettype wire
